// ---- design/anc_cfg.svh ----
// Offsets, fields, reset values and timing counts of the negotiation block
`ifndef ANC_CFG_SVH
`define ANC_CFG_SVH

// Register indices; byte address is four times the index
`define ANC_IDX_CONTROL 6'h00
`define ANC_IDX_STATUS 6'h01
`define ANC_IDX_ADVERT 6'h04
`define ANC_IDX_PARTNER 6'h05
`define ANC_IDX_EXPANSION 6'h06
`define ANC_IDX_SUMMARY 6'h10

// Control register fields
`define ANC_CTL_SPEED 13
`define ANC_CTL_NEGOTIATE_STRAP_ENABLE 12
`define ANC_CTL_RESTART 9
`define ANC_CTL_DUPLEX 8

// Ability field within advertisement and partner words
`define ANC_ABIL_HI 8
`define ANC_ABIL_LO 5
`define ANC_SELECTOR 5'h01
`define ANC_ADV_WMASK 16'hbfe0
`define ANC_PD_100 16'h0081
`define ANC_PD_10 16'h0021
`define ANC_WORD_RF 13
`define ANC_WORD_NP 15

// Fixed bits of the basic status register
`define ANC_STATUS_CONST 16'h7849

// Timing
`define ANC_CLK_HZ 50000000
`define ANC_BREAK_MS 1500
`define ANC_DONE_MS 3000
`define ANC_BREAK_CYCLES (`ANC_BREAK_MS * (`ANC_CLK_HZ / 1000))
`define ANC_DONE_CYCLES (`ANC_DONE_MS * (`ANC_CLK_HZ / 1000))

// Bus answers
`define ANC_RESP_OKAY 2'h0
`define ANC_RESP_SLVERR 2'h2

`endif

// ---- design/anc_pkg.sv ----
// Types of the negotiation block
package anc_pkg;

    typedef enum logic [4:0] {
        ST_FORCED = 5'h01,
        ST_BREAK = 5'h02,
        ST_ABILITY = 5'h04,
        ST_LINK_WAIT = 5'h08,
        ST_GOOD = 5'h10
    } anc_state_t;

    typedef struct packed {
        logic [4:0] sync1;
        logic [4:0] sync2;
        logic [1:0] strap_cnt;
        logic strapped;
        logic negotiate_strap_enable;
        logic armed;
        logic restart;
        logic speed;
        logic duplex;
        logic [15:0] adv;
        logic [15:0] lp;
        logic lp_an_able;
        logic page_rx;
        logic pd_fault;
        logic an_done;
        logic link_up;
        logic spd100;
        logic full;
        logic flp_en;
        logic halt;
        anc_state_t state;
        logic [27:0] timer;
        logic [3:0] res;
        logic aw_held;
        logic [5:0] aw_idx;
        logic w_held;
        logic [15:0] w_data;
        logic [1:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [15:0] rdata;
    } anc_regs_t;

endpackage

// ---- design/anc_autoneg.sv ----
// Auto-negotiation control with straps, parallel detect and AXI4-Lite registers
//
// Function
// - Enable strap low forces mode from mode straps.
// - Enable strap high advertises abilities set by mode straps.
// - Sampled straps load advertisement bits 8 to 5.
// - Control register writes override strap choice; after enable strap low, bit 12 acts only once it has been written clear.
// - Bursts carry the advertisement register.
// - Priority: 100 full, 100 half, 10 full, 10 half.
// - Speed and duplex bits act only with negotiation off.
// - Summary status shows resolved speed once link is up.
// - Status ability bits fixed ones; 100BASE-T4 zero.
// - Status shows complete, remote fault, link, preamble suppression.
// - Advertisement defaults to all, or to the mode strap choice with enable strap high; cleared bits stop being sent.
// - Partner register captures base and next page words.
// - Parallel detect loads partner register with 0081h or 0021h.
// - Expansion shows fault, next pages, page received, partner able.
// - Receiver link status picks parallel detect technology.
// - Parallel detect completion shows partner-able zero.
// - Both links good at once sets detect fault; no link sets none.
// - Control bit 9 restarts negotiation when written together with bit 12.
// - Link loss in negotiated mode resumes negotiation.
// - Renegotiation halts pulses for 1500 ms, then sends bursts.
// - Negotiation completes within about 2 to 3 seconds.
`timescale 1ns/1ns
`include "anc_cfg.svh"

module anc_autoneg #(
    parameter logic [27:0] BREAK_CYCLES = 28'(`ANC_BREAK_CYCLES),
    parameter logic [27:0] DONE_CYCLES = 28'(`ANC_DONE_CYCLES)
) (
    // Clock, reset, enable
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_ce,
    // Strap pins
    input wire logic i_negotiate_strap_enable,
    input wire logic i_mode_strap_high,
    input wire logic i_mode_strap_low,
    // Receiver link status
    input wire logic i_link_10_good,
    input wire logic i_link_100_good,
    // Code word receiver
    input wire logic i_rx_word_valid,
    input wire logic [15:0] i_rx_word,
    // Transmit side
    output logic o_fast_pulse_burst_en,
    output logic [15:0] o_tx_word,
    output logic o_tx_halt,
    // Resolved mode
    output logic o_link_up,
    output logic o_speed_100,
    output logic o_full_duplex,
    output logic o_an_complete,
    // AXI4-Lite write
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // AXI4-Lite read
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready
);

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Ability field {100F,100H,10F,10H} chosen by the straps
    function automatic logic [3:0] anc_strap_abil(input logic en, input logic hi, input logic lo);
        logic [3:0] a;
        a = 4'hf;
        if (en) begin
            unique case ({hi, lo})
                2'b00: a = 4'h3;
                2'b01: a = 4'hc;
                2'b10: a = 4'h5;
                2'b11: a = 4'hf;
            endcase
        end
        return a;
    endfunction

    // Highest common ability as one-hot
    function automatic logic [3:0] anc_pick(input logic [3:0] c);
        logic [3:0] r;
        r = 4'h0;
        if (c[3]) r = 4'h8;
        else if (c[2]) r = 4'h4;
        else if (c[1]) r = 4'h2;
        else if (c[0]) r = 4'h1;
        return r;
    endfunction

    function automatic logic [15:0] anc_merge(input logic [15:0] old, input logic [15:0] d,
                                              input logic [1:0] strb);
        logic [15:0] m;
        m = old;
        if (strb[0]) m[7:0] = d[7:0];
        if (strb[1]) m[15:8] = d[15:8];
        return m;
    endfunction

    function automatic logic anc_mapped(input logic [5:0] idx);
        return idx == `ANC_IDX_CONTROL || idx == `ANC_IDX_STATUS || idx == `ANC_IDX_ADVERT
            || idx == `ANC_IDX_PARTNER || idx == `ANC_IDX_EXPANSION
            || idx == `ANC_IDX_SUMMARY;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State

    anc_pkg::anc_regs_t st;
    anc_pkg::anc_regs_t next_st;

    logic strap_en;
    logic strap_hi;
    logic strap_lo;
    logic link10;
    logic link100;
    logic aw_fire;
    logic w_fire;
    logic do_write;
    logic do_read;
    logic [5:0] r_idx;
    logic [15:0] wr_val;
    logic reneg;
    logic [3:0] common;
    logic res_link;
    logic [15:0] ctrl_rd;
    logic [15:0] stat_rd;
    logic [15:0] exp_rd;
    logic [15:0] sum_rd;

    assign strap_en = st.sync2[4];
    assign strap_hi = st.sync2[3];
    assign strap_lo = st.sync2[2];
    assign link10 = st.sync2[1];
    assign link100 = st.sync2[0];
    assign common = st.adv[`ANC_ABIL_HI:`ANC_ABIL_LO] & st.lp[`ANC_ABIL_HI:`ANC_ABIL_LO];
    assign res_link = (st.res[3] | st.res[2]) ? link100 : link10;

    assign ctrl_rd = {2'h0, st.speed, st.negotiate_strap_enable, 2'h0, st.restart, st.duplex, 8'h00};
    assign stat_rd = `ANC_STATUS_CONST
        | {10'h000, st.an_done, st.lp[`ANC_WORD_RF], 1'b0, st.link_up, 2'h0};
    assign exp_rd = {11'h000, st.pd_fault, st.lp[`ANC_WORD_NP] & st.lp_an_able, 1'b1,
        st.page_rx, st.lp_an_able};
    assign sum_rd = {11'h000, st.an_done, 1'b0, st.full & st.link_up,
        ~st.spd100 & st.link_up, st.link_up};

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_st = st;
        aw_fire = i_awvalid & st.awready;
        w_fire = i_wvalid & st.wready;
        do_read = i_arvalid & st.arready;
        r_idx = i_araddr[7:2];
        do_write = st.aw_held & st.w_held & ~st.bvalid;
        wr_val = 16'h0000;
        reneg = 1'b0;

        next_st.sync1 = {i_negotiate_strap_enable, i_mode_strap_high, i_mode_strap_low,
            i_link_10_good, i_link_100_good};
        next_st.sync2 = st.sync1;

        // Straps caught once the synchroniser has settled
        if (!st.strapped) begin
            next_st.strap_cnt = st.strap_cnt + 2'h1;
            if (st.strap_cnt == 2'h3) begin
                next_st.strapped = 1'b1;
                next_st.negotiate_strap_enable = strap_en;
                next_st.armed = strap_en;
                next_st.speed = strap_hi;
                next_st.duplex = strap_lo;
                next_st.adv = {7'h00, anc_strap_abil(strap_en, strap_hi, strap_lo),
                    `ANC_SELECTOR};
                next_st.state = strap_en ? anc_pkg::ST_BREAK : anc_pkg::ST_FORCED;
                next_st.timer = '0;
            end
        end

        // Write: address and data in either order
        if (aw_fire) begin
            next_st.aw_held = 1'b1;
            next_st.aw_idx = i_awaddr[7:2];
        end
        if (w_fire) begin
            next_st.w_held = 1'b1;
            next_st.w_data = i_wdata[15:0];
            next_st.w_strb = i_wstrb[1:0];
        end
        if (do_write) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = anc_mapped(st.aw_idx) ? `ANC_RESP_OKAY : `ANC_RESP_SLVERR;
            if (st.aw_idx == `ANC_IDX_CONTROL) begin
                wr_val = anc_merge(ctrl_rd, st.w_data, st.w_strb);
                next_st.speed = wr_val[`ANC_CTL_SPEED];
                next_st.duplex = wr_val[`ANC_CTL_DUPLEX];
                next_st.negotiate_strap_enable = wr_val[`ANC_CTL_NEGOTIATE_STRAP_ENABLE] & st.armed;
                if (!wr_val[`ANC_CTL_NEGOTIATE_STRAP_ENABLE]) begin
                    next_st.armed = 1'b1;
                end
                // Negotiation starts on a rising enable or an explicit restart
                if (wr_val[`ANC_CTL_NEGOTIATE_STRAP_ENABLE] && st.armed
                    && (!st.negotiate_strap_enable || wr_val[`ANC_CTL_RESTART])) begin
                    next_st.restart = 1'b1;
                end
            end else if (st.aw_idx == `ANC_IDX_ADVERT) begin
                wr_val = anc_merge(st.adv, st.w_data, st.w_strb);
                next_st.adv = (wr_val & `ANC_ADV_WMASK) | {11'h000, `ANC_SELECTOR};
            end
        end
        if (st.bvalid && i_bready) begin
            next_st.bvalid = 1'b0;
        end
        next_st.awready = ~next_st.aw_held & ~next_st.bvalid;
        next_st.wready = ~next_st.w_held & ~next_st.bvalid;

        // Read channel
        if (do_read) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = anc_mapped(r_idx) ? `ANC_RESP_OKAY : `ANC_RESP_SLVERR;
            unique case (r_idx)
                `ANC_IDX_CONTROL: next_st.rdata = ctrl_rd;
                `ANC_IDX_STATUS: next_st.rdata = stat_rd;
                `ANC_IDX_ADVERT: next_st.rdata = st.adv;
                `ANC_IDX_PARTNER: next_st.rdata = st.lp;
                `ANC_IDX_EXPANSION: next_st.rdata = exp_rd;
                `ANC_IDX_SUMMARY: next_st.rdata = sum_rd;
                default: next_st.rdata = 16'h0000;
            endcase
            // Clear on read; a same-cycle event still sets
            if (r_idx == `ANC_IDX_EXPANSION) begin
                next_st.page_rx = 1'b0;
                next_st.pd_fault = 1'b0;
            end
        end else if (st.rvalid && i_rready) begin
            next_st.rvalid = 1'b0;
        end
        next_st.arready = ~next_st.rvalid;

        ////////////////////////////////////////////////////////////////////////////
        // Negotiation sequencer
        if (st.strapped) begin
            next_st.timer = st.timer + 28'h1;
            reneg = st.restart;
            if (!st.negotiate_strap_enable) begin
                // Forced mode follows control bits
                next_st.state = anc_pkg::ST_FORCED;
                next_st.restart = 1'b0;
            end else if (reneg) begin
                next_st.state = anc_pkg::ST_BREAK;
                next_st.restart = 1'b0;
                next_st.timer = '0;
            end
            if (!st.negotiate_strap_enable || reneg) begin
                next_st.an_done = 1'b0;
                next_st.link_up = 1'b0;
            end else begin
                unique case (st.state)
                    anc_pkg::ST_FORCED: begin
                        next_st.state = anc_pkg::ST_BREAK;
                        next_st.timer = '0;
                    end
                    anc_pkg::ST_BREAK: begin
                        if (st.timer >= BREAK_CYCLES - 28'h1) begin
                            next_st.state = anc_pkg::ST_ABILITY;
                            next_st.timer = '0;
                            next_st.lp = 16'h0000;
                            next_st.lp_an_able = 1'b0;
                        end
                    end
                    anc_pkg::ST_ABILITY: begin
                        if (i_rx_word_valid) begin
                            next_st.lp = i_rx_word;
                            next_st.lp_an_able = 1'b1;
                            next_st.page_rx = 1'b1;
                            next_st.res = anc_pick(st.adv[`ANC_ABIL_HI:`ANC_ABIL_LO]
                                & i_rx_word[`ANC_ABIL_HI:`ANC_ABIL_LO]);
                            if ((st.adv[`ANC_ABIL_HI:`ANC_ABIL_LO]
                                 & i_rx_word[`ANC_ABIL_HI:`ANC_ABIL_LO]) != 4'h0) begin
                                next_st.state = anc_pkg::ST_LINK_WAIT;
                            end
                        end else if (link10 ^ link100) begin
                            // Non-negotiating partner: one receiver has link
                            next_st.lp = link100 ? `ANC_PD_100 : `ANC_PD_10;
                            next_st.lp_an_able = 1'b0;
                            next_st.res = link100 ? 4'h4 : 4'h1;
                            next_st.state = anc_pkg::ST_LINK_WAIT;
                        end else if (link10 && link100) begin
                            next_st.pd_fault = 1'b1;
                        end
                        if (st.timer >= DONE_CYCLES - 28'h1) begin
                            next_st.state = anc_pkg::ST_BREAK;
                            next_st.timer = '0;
                        end
                    end
                    anc_pkg::ST_LINK_WAIT: begin
                        if (res_link) begin
                            next_st.state = anc_pkg::ST_GOOD;
                            next_st.an_done = 1'b1;
                            next_st.link_up = 1'b1;
                            next_st.spd100 = st.res[3] | st.res[2];
                            next_st.full = st.res[3] | st.res[1];
                        end else if (st.timer >= DONE_CYCLES - 28'h1) begin
                            next_st.state = anc_pkg::ST_BREAK;
                            next_st.timer = '0;
                        end
                    end
                    anc_pkg::ST_GOOD: begin
                        if (i_rx_word_valid) begin
                            next_st.lp = i_rx_word;
                            next_st.page_rx = 1'b1;
                        end
                        if (!res_link) begin
                            next_st.state = anc_pkg::ST_BREAK;
                            next_st.timer = '0;
                            next_st.an_done = 1'b0;
                            next_st.link_up = 1'b0;
                        end
                    end
                    default: begin
                        next_st.state = anc_pkg::ST_BREAK;
                        next_st.timer = '0;
                    end
                endcase
            end
            if (!st.negotiate_strap_enable) begin
                next_st.spd100 = st.speed;
                next_st.full = st.duplex;
                next_st.link_up = st.speed ? link100 : link10;
            end
            next_st.halt = next_st.state == anc_pkg::ST_BREAK;
            next_st.flp_en = next_st.state == anc_pkg::ST_ABILITY
                || next_st.state == anc_pkg::ST_LINK_WAIT;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st <= '0;
            st.state <= anc_pkg::ST_FORCED;
            st.adv <= {7'h00, 4'hf, `ANC_SELECTOR};
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    assign o_fast_pulse_burst_en = st.flp_en;
    assign o_tx_word = st.adv;
    assign o_tx_halt = st.halt;
    assign o_link_up = st.link_up;
    assign o_speed_100 = st.spd100;
    assign o_full_duplex = st.full;
    assign o_an_complete = st.an_done;
    assign o_awready = st.awready;
    assign o_wready = st.wready;
    assign o_bresp = st.bresp;
    assign o_bvalid = st.bvalid;
    assign o_arready = st.arready;
    assign o_rdata = {16'h0000, st.rdata};
    assign o_rresp = st.rresp;
    assign o_rvalid = st.rvalid;

endmodule // anc_autoneg

// ---- verif/anc_partner.sv ----
// Remote partner: one code word per burst, or plain link signals
`timescale 1ns/1ns
module anc_partner (
    // Clock, reset, scenario control
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic [2:0] i_mode,
    input wire logic [15:0] i_word,
    // Device transmit side
    input wire logic i_burst_en,
    input wire logic [15:0] i_tx_word,
    input wire logic i_halt,
    // Device receive side
    output logic o_word_valid,
    output logic [15:0] o_word,
    output logic o_link_10,
    output logic o_link_100
);
    logic sent;
    logic [3:0] common;
    assign common = i_tx_word[8:5] & i_word[8:5];
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sent <= 1'b0;
            o_word_valid <= 1'b0;
            o_word <= 16'h0000;
            o_link_10 <= 1'b0;
            o_link_100 <= 1'b0;
        end else begin
            o_word_valid <= 1'b0;
            // Word lines are junk outside a valid pulse
            o_word <= ~o_word;
            if (i_halt || i_mode > 3'h3) begin
                sent <= 1'b0;
                o_link_10 <= 1'b0;
                o_link_100 <= 1'b0;
            end else if (i_mode == 3'h0) begin
                if (i_burst_en && !sent) begin
                    sent <= 1'b1;
                    o_word_valid <= 1'b1;
                    o_word <= i_word;
                    // Latched so later advert writes cannot move it
                    o_link_100 <= |common[3:2];
                    o_link_10 <= ~|common[3:2] & |common[1:0];
                end
            end else begin
                o_link_10 <= i_mode[0];
                o_link_100 <= i_mode[1];
            end
        end
    end
endmodule // anc_partner

// ---- verif/anc_autoneg_sva.sv ----
// Checker of bus handshakes and renegotiation timing
`timescale 1ns/1ns
module anc_autoneg_sva (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // Bus
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic i_rready,
    input wire logic o_rvalid,
    input wire logic [31:0] o_rdata,
    input wire logic i_bready,
    input wire logic o_bvalid,
    input wire logic [1:0] o_bresp,
    input wire logic o_awready,
    // Link
    input wire logic o_tx_halt,
    input wire logic o_fast_pulse_burst_en,
    input wire logic [15:0] o_tx_word,
    input wire logic o_link_up
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_arst_n);
    a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("read late");
    a_read_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read dropped");
    a_write_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write dropped");
    a_write_block: assert property (o_bvalid |-> !o_awready)
        else $error("address taken early");
    a_halt_silent: assert property (o_tx_halt |-> !o_fast_pulse_burst_en && !o_link_up)
        else $error("activity in break");
    a_break_len: assert property ($rose(o_tx_halt) |-> o_tx_halt[*8])
        else $error("break short");
    a_resume_burst: assert property ($fell(o_tx_halt) |-> o_fast_pulse_burst_en)
        else $error("no bursts");
    a_burst_word: assert property (o_fast_pulse_burst_en |-> o_tx_word[4:0] == 5'h01)
        else $error("bad selector");
endmodule // anc_autoneg_sva

// ---- verif/tb_anc_autoneg.sv ----
// Self-checking bench for the negotiation block
`timescale 1ns/1ns
`include "anc_cfg.svh"
module tb_anc_autoneg;
    logic i_clk_sys = 1'b0, i_arst_n = 1'b0, st_en = 1'b0, st_hi = 1'b0, st_lo = 1'b0;
    logic l10, l100, rxv, burst, halt, link, spd, full, done;
    logic [15:0] rxw, txw, p_word = 16'h0001;
    logic [2:0] p_mode = 3'h4;
    logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
    logic [31:0] i_wdata = 32'h0, o_rdata;
    logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0] o_bresp, o_rresp;
    int n_errors = 0, samples_checked = 0, cycles = 0;
    initial begin
        forever #10 i_clk_sys = ~i_clk_sys;
    end
    // Short break and timeout keep the run brief
    anc_autoneg #(.BREAK_CYCLES(28'd20), .DONE_CYCLES(28'd200)) DUT (
        .i_clk_sys, .i_arst_n, .i_ce(1'b1),
        .i_negotiate_strap_enable(st_en), .i_mode_strap_high(st_hi), .i_mode_strap_low(st_lo),
        .i_link_10_good(l10), .i_link_100_good(l100), .i_rx_word_valid(rxv), .i_rx_word(rxw),
        .o_fast_pulse_burst_en(burst), .o_tx_word(txw), .o_tx_halt(halt), .o_link_up(link),
        .o_speed_100(spd), .o_full_duplex(full), .o_an_complete(done),
        .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb(4'hf), .i_wvalid, .o_wready,
        .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp,
        .o_rvalid, .i_rready);
    anc_partner u_partner (.i_clk_sys, .i_arst_n, .i_mode(p_mode),
        .i_word(p_word), .i_burst_en(burst), .i_tx_word(txw), .i_halt(halt),
        .o_word_valid(rxv), .o_word(rxw), .o_link_10(l10), .o_link_100(l100));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] strap_adv(input logic [2:0] s);
        if (!s[2]) return 16'h01e1;
        case (s[1:0])
            2'b00: return 16'h0061;
            2'b01: return 16'h0181;
            2'b10: return 16'h00a1;
            default: return 16'h01e1;
        endcase
    endfunction
    // Best common ability as {speed_100, full}
    function automatic logic [1:0] resolve(input logic [3:0] c);
        if (c[3]) return 2'b11;
        if (c[2]) return 2'b10;
        if (c[1]) return 2'b01;
        return 2'b00;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
        @(posedge i_clk_sys);
        i_awaddr <= a;
        i_wdata <= {16'h0000, d};
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        do begin
            @(posedge i_clk_sys);
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
        end while (o_bvalid !== 1'b1);
        i_bready <= 1'b0;
        r = o_bresp;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk_sys);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        do begin
            @(posedge i_clk_sys);
            if (o_arready) i_arvalid <= 1'b0;
        end while (o_rvalid !== 1'b1);
        i_rready <= 1'b0;
        d = o_rdata;
        check("rresp", 32'(o_rresp), 32'(a == 8'h0c ? `ANC_RESP_SLVERR : `ANC_RESP_OKAY));
    endtask
    task automatic go(input logic [15:0] ctl, input logic hx);
        logic [1:0] r;
        wr(8'h00, ctl, r);
        repeat (2) @(posedge i_clk_sys);
        #1 check("halt", 32'(halt), 32'(hx));
    endtask
    task automatic wait_done();
        int t;
        t = 0;
        while (done !== 1'b1 && t < 400) begin
            @(posedge i_clk_sys);
            t++;
        end
        check("complete", 32'(done), 32'h1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge i_clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    initial begin
        logic [31:0] d;
        logic [1:0] r, m;
        logic [3:0] la, pa;
        logic rf;
        d = $urandom(28);
        for (int s = 7; s >= 0; s--) begin
            i_arst_n <= 1'b0;
            {st_en, st_hi, st_lo} <= 3'(s);
            repeat (3) @(posedge i_clk_sys);
            i_arst_n <= 1'b1;
            repeat (8) @(posedge i_clk_sys);
            rd(8'h10, d);
            check("advert", d, 32'(strap_adv(3'(s))));
            rd(8'h00, d);
            check("control", d, 32'(s[2] << 12 | s[1] << 13 | s[0] << 8));
            if (s < 4) check("forced", 32'({spd, full}), 32'(s));
        end
        go(16'h1000, 1'b0);
        go(16'h2100, 1'b0);
        check("forced 100 full", 32'({spd, full}), 32'h3);
        go(16'h0000, 1'b0);
        check("forced 10 half", 32'({spd, full}), 32'h0);
        go(16'h1000, 1'b1);
        p_mode <= 3'h0;
        for (int k = 0; k < 5; k++) begin
            la = (k == 0) ? 4'hf : 4'($urandom_range(15, 1));
            pa = (k == 0) ? 4'h1 : 4'($urandom_range(15, 1));
            if ((la & pa) == 4'h0) pa = la;
            rf = 1'($urandom);
            m = 2'($urandom);
            p_word <= {2'b00, rf, 4'h0, pa, 5'h01};
            wr(8'h10, {7'h00, la, 5'h01}, r);
            go({2'b00, m[1], 1'b1, 2'b00, 1'b1, m[0], 8'h00}, 1'b1);
            wait_done();
            m = resolve(la & pa);
            check("mode", 32'({spd, full}), 32'(m));
            rd(8'h14, d);
            check("partner", d, 32'(p_word));
            rd(8'h04, d);
            check("status", d, 32'(`ANC_STATUS_CONST | 16'h0024 | {rf, 4'h0}));
            rd(8'h40, d);
            check("summary", d, 32'({1'b1, 1'b0, m[0], ~m[1], 1'b1}));
            rd(8'h00, d);
            check("restart bit", 32'(d[9]), 32'h0);
            rd(8'h18, d);
            check("partner able", 32'(d[0]), 32'h1);
        end
        p_mode <= 3'h4;
        repeat (10) @(posedge i_clk_sys);
        check("link lost", 32'({link, done}), 32'h0);
        check("renegotiating", 32'(halt | burst), 32'h1);
        p_mode <= 3'h0;
        wait_done();
        wr(8'h10, 16'h01e1, r);
        for (int k = 1; k <= 2; k++) begin
            p_mode <= 3'(k);
            go(16'h1200, 1'b1);
            wait_done();
            check("pd speed", 32'(spd), 32'(k == 2));
            rd(8'h14, d);
            check("pd partner", d, 32'(k == 2 ? `ANC_PD_100 : `ANC_PD_10));
            rd(8'h18, d);
            check("pd able", 32'(d[0]), 32'h0);
        end
        p_mode <= 3'h3;
        go(16'h1200, 1'b1);
        repeat (40) @(posedge i_clk_sys);
        rd(8'h18, d);
        check("pd fault", 32'({d[4], done}), 32'h2);
        rd(8'h0c, d);
        check("unmapped data", d, 32'h0);
        wr(8'h0c, 16'hffff, r);
        check("unmapped write", 32'(r), 32'(`ANC_RESP_SLVERR));
        tally_and_finish();
    end
endmodule // tb_anc_autoneg
bind anc_autoneg anc_autoneg_sva u_sva (.i_clk_sys, .i_arst_n, .i_arvalid, .o_arready,
    .i_rready, .o_rvalid, .o_rdata, .i_bready, .o_bvalid, .o_bresp, .o_awready, .o_tx_halt,
    .o_fast_pulse_burst_en, .o_tx_word, .o_link_up);
